// ==== cas_sequencer.sv ====
// card activation sequencer: supply, reset, clock and data channel ordering
`timescale 1ns/1ns
// Notes on behaviour
// - power_down_n rising holds reset, clock, data low then enables supply
// - data and reset channels open only after supply power-good
// - clock channel opens on second host clock rising edge after data opens
// - power_down_n falling first closes reset channel, reset driven low
// - clock channel closes two host clock cycles after power_down_n falls
// - stopped host clock: clock channel closes about 9 us after the fall
// - data channel closes and line driven low about 9 us after the fall
// - supply removed last, only after data line is driven low
// - host clock and reset pass to card clock and reset outputs
// - card supply level is 3.3 V or 5.0 V by level select
// - data channel conveys a low either way, off when nobody drives
// - released data line gets a pull-up current boost
// - clock fault: wait detection delay, then reduce clock drive
// - no fault status output; pins just tolerate the fault
module cas_sequencer (
   // system clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_resetn,
   // host clock, also the link clock domain
   input  wire logic i_host_clk,
   // host controls
   input  wire logic i_power_down_n,
   input  wire logic i_supply_level_select,
   input  wire logic i_host_reset_in,
   // supply regulator
   input  wire logic i_supply_good,
   output logic      o_supply_en,
   output logic      o_supply_5v_sel,
   // card reset and clock
   output logic      o_card_rst,
   output logic      o_card_clk,
   input  wire logic i_clk_fault,
   output logic      o_clk_drive_reduced,
   // host-side data line, open drain
   input  wire logic i_host_data,
   output logic      o_host_data,
   output logic      o_host_data_oe,
   output logic      o_host_pullup_en,
   // card-side data line, open drain
   input  wire logic i_card_io,
   output logic      o_card_io,
   output logic      o_card_io_oe,
   output logic      o_card_pullup_en
);

   // synchronisers for asynchronous inputs into the system domain
   logic [1:0] pdn_sync_reg;
   logic [1:0] sel_sync_reg;
   logic [1:0] hrst_sync_reg;
   logic [1:0] hclk_sync_reg;
   logic [1:0] good_sync_reg;
   logic [1:0] fault_sync_reg;
   logic [1:0] hdat_sync_reg;
   logic [1:0] cio_sync_reg;
   logic [1:0] act_ack_sync_reg;
   logic [1:0] deact_ack_sync_reg;

   // sequencer state
   cas_pkg::cas_state_t state_reg;
   logic [10:0]         tmo_reg;
   logic                rst_chan_reg;
   logic                clk_chan_reg;
   logic                data_chan_reg;
   logic                deact_req_reg;
   logic                act_armed_reg;
   logic                deact_armed_reg;

   // link domain
   logic [1:0] data_chan_lsync_reg;
   logic [1:0] deact_lsync_reg;
   logic [1:0] act_cnt_reg;
   logic [1:0] deact_cnt_reg;
   logic       act_ack_reg;
   logic       deact_ack_reg;

   // data path and fault state
   logic       card_drv_reg;
   logic       host_drv_reg;
   logic [7:0] card_boost_reg;
   logic [7:0] host_boost_reg;
   logic [1:0] card_echo_reg;
   logic [1:0] host_echo_reg;
   logic [7:0] fault_cnt_reg;

   // two-flop synchronisers; only bit 1 is ever read by logic
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pdn_sync_reg       <= 2'h0;
         sel_sync_reg       <= 2'h0;
         hrst_sync_reg      <= 2'h0;
         hclk_sync_reg      <= 2'h0;
         good_sync_reg      <= 2'h0;
         fault_sync_reg     <= 2'h0;
         hdat_sync_reg      <= 2'h3;
         cio_sync_reg       <= 2'h3;
         act_ack_sync_reg   <= 2'h0;
         deact_ack_sync_reg <= 2'h0;
      end else begin
         pdn_sync_reg       <= {pdn_sync_reg[0], i_power_down_n};
         sel_sync_reg       <= {sel_sync_reg[0], i_supply_level_select};
         hrst_sync_reg      <= {hrst_sync_reg[0], i_host_reset_in};
         hclk_sync_reg      <= {hclk_sync_reg[0], i_host_clk};
         good_sync_reg      <= {good_sync_reg[0], i_supply_good};
         fault_sync_reg     <= {fault_sync_reg[0], i_clk_fault};
         hdat_sync_reg      <= {hdat_sync_reg[0], i_host_data};
         cio_sync_reg       <= {cio_sync_reg[0], i_card_io};
         act_ack_sync_reg   <= {act_ack_sync_reg[0], act_ack_reg};
         deact_ack_sync_reg <= {deact_ack_sync_reg[0], deact_ack_reg};
      end
   end

   // link domain: count host clock rising edges after the data channel opens
   always_ff @(posedge i_host_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         data_chan_lsync_reg <= 2'h0;
         act_cnt_reg         <= 2'h0;
         act_ack_reg         <= 1'b0;
      end else begin
         data_chan_lsync_reg <= {data_chan_lsync_reg[0], data_chan_reg};
         if (!data_chan_lsync_reg[1]) begin
            act_cnt_reg <= 2'h0;
            act_ack_reg <= 1'b0;
         end else if (act_cnt_reg != cas_pkg::ACT_CLK_EDGES) begin
            act_cnt_reg <= act_cnt_reg + 2'h1;
            act_ack_reg <= (act_cnt_reg + 2'h1) == cas_pkg::ACT_CLK_EDGES;
         end
      end
   end

   // link domain: two host clock cycles after deactivation starts
   // a stopped host clock never acks; the system timeout takes over
   always_ff @(posedge i_host_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         deact_lsync_reg <= 2'h0;
         deact_cnt_reg   <= 2'h0;
         deact_ack_reg   <= 1'b0;
      end else begin
         deact_lsync_reg <= {deact_lsync_reg[0], deact_req_reg};
         if (!deact_lsync_reg[1]) begin
            deact_cnt_reg <= 2'h0;
            deact_ack_reg <= 1'b0;
         end else if (deact_cnt_reg != cas_pkg::DEACT_CLK_EDGES) begin
            deact_cnt_reg <= deact_cnt_reg + 2'h1;
            deact_ack_reg <= (deact_cnt_reg + 2'h1) == cas_pkg::DEACT_CLK_EDGES;
         end
      end
   end

   // activation and deactivation order
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg     <= cas_pkg::CAS_OFF;
         tmo_reg       <= 11'h000;
         rst_chan_reg  <= 1'b0;
         clk_chan_reg  <= 1'b0;
         data_chan_reg <= 1'b0;
         deact_req_reg <= 1'b0;
         o_supply_en   <= 1'b0;
      end else begin
         case (state_reg)
            cas_pkg::CAS_OFF: begin
               if (pdn_sync_reg[1]) begin
                  o_supply_en <= 1'b1;
                  state_reg   <= cas_pkg::CAS_HOLD;
               end
            end
            cas_pkg::CAS_HOLD: begin
               if (!pdn_sync_reg[1]) begin
                  deact_req_reg <= 1'b1;
                  tmo_reg       <= 11'h000;
                  state_reg     <= cas_pkg::CAS_DEACT;
               end else if (good_sync_reg[1]) begin
                  data_chan_reg <= 1'b1;
                  rst_chan_reg  <= 1'b1;
                  state_reg     <= cas_pkg::CAS_WAIT_CLK;
               end
            end
            cas_pkg::CAS_WAIT_CLK: begin
               if (!pdn_sync_reg[1]) begin
                  rst_chan_reg  <= 1'b0;
                  deact_req_reg <= 1'b1;
                  tmo_reg       <= 11'h000;
                  state_reg     <= cas_pkg::CAS_DEACT;
               end else if (act_ack_sync_reg[1] && act_armed_reg) begin
                  clk_chan_reg <= 1'b1;
                  state_reg    <= cas_pkg::CAS_RUN;
               end
            end
            cas_pkg::CAS_RUN: begin
               if (!pdn_sync_reg[1]) begin
                  rst_chan_reg  <= 1'b0;
                  deact_req_reg <= 1'b1;
                  tmo_reg       <= 11'h000;
                  state_reg     <= cas_pkg::CAS_DEACT;
               end
            end
            cas_pkg::CAS_DEACT: begin
               rst_chan_reg <= 1'b0;
               tmo_reg      <= tmo_reg + 11'h001;
               if (deact_ack_sync_reg[1] && deact_armed_reg) begin
                  clk_chan_reg <= 1'b0;
               end
               if (tmo_reg == cas_pkg::DEACT_TIMEOUT_CYC - 11'h001) begin
                  clk_chan_reg  <= 1'b0;
                  data_chan_reg <= 1'b0;
                  state_reg     <= cas_pkg::CAS_SUPPLY_DOWN;
               end
            end
            cas_pkg::CAS_SUPPLY_DOWN: begin
               // supply goes last, once the card line is driven low
               if (o_card_io_oe) begin
                  o_supply_en   <= 1'b0;
                  deact_req_reg <= 1'b0;
                  state_reg     <= cas_pkg::CAS_OFF;
               end
            end
            default: begin
               state_reg <= cas_pkg::CAS_OFF;
            end
         endcase
      end
   end

   // ack arming: an ack left high when the host clock stopped mid-handshake
   // must read low once in the waiting state, else a channel moves early
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         act_armed_reg   <= 1'b0;
         deact_armed_reg <= 1'b0;
      end else begin
         if (state_reg != cas_pkg::CAS_WAIT_CLK) begin
            act_armed_reg <= 1'b0;
         end else if (!act_ack_sync_reg[1]) begin
            act_armed_reg <= 1'b1;
         end
         if (state_reg != cas_pkg::CAS_DEACT) begin
            deact_armed_reg <= 1'b0;
         end else if (!deact_ack_sync_reg[1]) begin
            deact_armed_reg <= 1'b1;
         end
      end
   end

   // supply level follows the select input
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_supply_5v_sel <= 1'b0;
      end else begin
         o_supply_5v_sel <= sel_sync_reg[1];
      end
   end

   // reset and clock pass-through, held low while the channel is closed
   // clock is resampled at 125 MHz, good for host clocks up to ~10 MHz
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_card_rst <= 1'b0;
         o_card_clk <= 1'b0;
      end else begin
         o_card_rst <= hrst_sync_reg[1] & rst_chan_reg;
         o_card_clk <= hclk_sync_reg[1] & clk_chan_reg;
      end
   end

   // echo blanking: a line we just released still reads low through its
   // synchroniser; without a hold-off the two sides would ping-pong
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         card_echo_reg <= 2'h3;
         host_echo_reg <= 2'h0;
      end else begin
         card_echo_reg <= {card_echo_reg[0], o_card_io_oe | card_drv_reg};
         host_echo_reg <= {host_echo_reg[0], o_host_data_oe | host_drv_reg};
      end
   end

   // data channel ownership; whoever pulled low first owns it, avoiding latch-up
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         card_drv_reg <= 1'b0;
         host_drv_reg <= 1'b0;
      end else if (!data_chan_reg) begin
         card_drv_reg <= 1'b0;
         host_drv_reg <= 1'b0;
      end else begin
         // the far side is heard only once our own drive has cleared
         card_drv_reg <= !hdat_sync_reg[1] & !host_drv_reg & !o_host_data_oe
                         & !(|host_echo_reg);
         host_drv_reg <= !cio_sync_reg[1] & !card_drv_reg & !o_card_io_oe
                         & !(|card_echo_reg);
      end
   end

   // open-drain drivers; closed channel forces the card line low
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_card_io      <= 1'b0;
         o_card_io_oe   <= 1'b1;
         o_host_data    <= 1'b0;
         o_host_data_oe <= 1'b0;
      end else begin
         o_card_io      <= 1'b0;
         o_host_data    <= 1'b0;
         o_card_io_oe   <= !data_chan_reg | card_drv_reg;
         o_host_data_oe <= data_chan_reg & host_drv_reg;
      end
   end

   // pull-up boost after release: short burst keeps static current low
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         card_boost_reg   <= 8'h00;
         host_boost_reg   <= 8'h00;
         o_card_pullup_en <= 1'b0;
         o_host_pullup_en <= 1'b0;
      end else begin
         if (o_card_io_oe && !(!data_chan_reg | card_drv_reg)) begin
            card_boost_reg <= cas_pkg::BOOST_CYC;
         end else if (card_boost_reg != 8'h00) begin
            card_boost_reg <= card_boost_reg - 8'h01;
         end
         if (o_host_data_oe && !(data_chan_reg & host_drv_reg)) begin
            host_boost_reg <= cas_pkg::BOOST_CYC;
         end else if (host_boost_reg != 8'h00) begin
            host_boost_reg <= host_boost_reg - 8'h01;
         end
         o_card_pullup_en <= card_boost_reg != 8'h00;
         o_host_pullup_en <= host_boost_reg != 8'h00;
      end
   end

   // clock fault: no status output, drive is reduced after a delay
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         fault_cnt_reg       <= 8'h00;
         o_clk_drive_reduced <= 1'b0;
      end else if (!fault_sync_reg[1]) begin
         fault_cnt_reg       <= 8'h00;
         o_clk_drive_reduced <= 1'b0;
      end else if (fault_cnt_reg != cas_pkg::FAULT_DELAY_CYC) begin
         fault_cnt_reg <= fault_cnt_reg + 8'h01;
      end else begin
         o_clk_drive_reduced <= 1'b1;
      end
   end

endmodule

// ==== cas_pkg.sv ====
// constants and state type for the card activation sequencer
package cas_pkg;

   // system clock period, in ps
   localparam int unsigned SYS_CLK_PERIOD_PS = 8000;

   // deactivation timeout for a stopped host clock, in ns
   localparam int unsigned DEACT_TIMEOUT_NS = 9000;
   localparam int unsigned DEACT_TIMEOUT_CYC_I = (DEACT_TIMEOUT_NS * 1000) / SYS_CLK_PERIOD_PS;
   localparam logic [10:0] DEACT_TIMEOUT_CYC = DEACT_TIMEOUT_CYC_I[10:0];

   // clock output fault detection delay, in ns
   localparam int unsigned FAULT_DELAY_NS = 1000;
   localparam int unsigned FAULT_DELAY_CYC_I =
      (FAULT_DELAY_NS * 1000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
   localparam logic [7:0] FAULT_DELAY_CYC = FAULT_DELAY_CYC_I[7:0];

   // pull-up boost after a data line is released, in ns
   localparam int unsigned BOOST_TIME_NS = 200;
   localparam int unsigned BOOST_CYC_I = (BOOST_TIME_NS * 1000) / SYS_CLK_PERIOD_PS;
   localparam logic [7:0] BOOST_CYC = BOOST_CYC_I[7:0];

   // host clock edges counted at the link
   localparam logic [1:0] ACT_CLK_EDGES   = 2'h2;
   localparam logic [1:0] DEACT_CLK_EDGES = 2'h2;

   // sequencer states
   typedef enum logic [2:0] {
      CAS_OFF,
      CAS_HOLD,
      CAS_WAIT_CLK,
      CAS_RUN,
      CAS_DEACT,
      CAS_SUPPLY_DOWN
   } cas_state_t;

endpackage

// ==== cas_seq_assertions.sv ====
// port-level assertions for the card activation sequencer
`timescale 1ns/1ns
module cas_seq_chk (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // inputs
   input wire logic i_power_down_n,
   input wire logic i_host_data,
   input wire logic i_supply_level_select,
   input wire logic i_supply_good,
   input wire logic i_clk_fault,
   input wire logic i_card_io,
   // outputs
   input wire logic o_supply_en,
   input wire logic o_supply_5v_sel,
   input wire logic o_card_rst,
   input wire logic o_card_clk,
   input wire logic o_clk_drive_reduced,
   input wire logic o_host_data_oe,
   input wire logic o_host_pullup_en,
   input wire logic o_card_io_oe
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   logic [7:0]  flt_cnt_reg;
   logic [10:0] dwn_cnt_reg;
   logic        dwn_arm_reg;
   // cycles since power_down_n fell; arm records an open data channel at the fall
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         dwn_cnt_reg <= 11'h000;
         dwn_arm_reg <= 1'b0;
      end else if (i_power_down_n) begin
         dwn_cnt_reg <= 11'h000;
         dwn_arm_reg <= !o_card_io_oe;
      end else if (dwn_cnt_reg != 11'h7ff) begin
         dwn_cnt_reg <= dwn_cnt_reg + 11'h001;
      end
   end
   // fault age, saturating so a long fault never wraps
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) flt_cnt_reg <= 8'h00;
      else if (!i_clk_fault) flt_cnt_reg <= 8'h00;
      else if (flt_cnt_reg != 8'hff) flt_cnt_reg <= flt_cnt_reg + 8'h01;
   end
   property p_off; !o_supply_en |-> !o_card_rst && !o_card_clk && o_card_io_oe; endproperty
   a_off: assert property (p_off) else $error("card pins live without supply");
   property p_open; $fell(o_card_io_oe) |-> o_supply_en && $past(i_supply_good, 3); endproperty
   a_open: assert property (p_open) else $error("data opened before supply good");
   property p_rst; !i_power_down_n [*6] |-> !o_card_rst; endproperty
   a_rst: assert property (p_rst) else $error("card reset not dropped");
   property p_io; i_host_data [*5] ##0 (dwn_arm_reg && !i_power_down_n &&
      dwn_cnt_reg < cas_pkg::DEACT_TIMEOUT_CYC - 11'h008) |-> !o_card_io_oe; endproperty
   a_io: assert property (p_io) else $error("data channel closed too early");
   property p_io_late; dwn_arm_reg && !i_power_down_n &&
      dwn_cnt_reg == cas_pkg::DEACT_TIMEOUT_CYC + 11'h010 |-> o_card_io_oe; endproperty
   a_io_late: assert property (p_io_late) else $error("data channel closed too late");
   property p_sup; $fell(o_supply_en) |->
      o_card_io_oe && $past(o_card_io_oe) && !o_card_clk; endproperty
   a_sup: assert property (p_sup) else $error("supply removed too early");
   property p_sel5; i_supply_level_select [*4] |-> o_supply_5v_sel; endproperty
   a_sel5: assert property (p_sel5) else $error("5v select not followed");
   property p_sel3; !i_supply_level_select [*4] |-> !o_supply_5v_sel; endproperty
   a_sel3: assert property (p_sel3) else $error("3v3 select not followed");
   property p_fwd; (!i_card_io && !o_card_io_oe) [*5] |-> o_host_data_oe; endproperty
   a_fwd: assert property (p_fwd) else $error("card low not passed to host");
   property p_boost; $fell(o_host_data_oe) |-> ##[0:2] o_host_pullup_en; endproperty
   a_boost: assert property (p_boost) else $error("no pull-up boost");
   property p_flt; $rose(o_clk_drive_reduced) |-> flt_cnt_reg >= cas_pkg::FAULT_DELAY_CYC;
   endproperty
   a_flt: assert property (p_flt) else $error("drive reduced too early");
   property p_fltx; !i_clk_fault [*5] |-> !o_clk_drive_reduced; endproperty
   a_fltx: assert property (p_fltx) else $error("drive stays reduced");
endmodule
bind cas_sequencer cas_seq_chk chk_u (.i_sys_clk, .i_resetn, .i_power_down_n, .i_host_data,
   .i_supply_level_select, .i_supply_good, .i_clk_fault, .i_card_io, .o_supply_en,
   .o_supply_5v_sel, .o_card_rst, .o_card_clk, .o_clk_drive_reduced, .o_host_data_oe,
   .o_host_pullup_en, .o_card_io_oe);

// ==== cas_card_model.sv ====
// contact card model: answers its reset by pulling the i/o line low
`timescale 1ns/1ns
module cas_card_model (
   // card-side pins
   input  wire logic       i_sys_clk,
   input  wire logic       i_supply_en,
   input  wire logic       i_card_rst,
   input  wire logic       i_dut_io_oe,
   input  wire logic [7:0] i_delay,
   output logic            o_card_io
);
   int   cnt;
   logic pull;
   // one answer per reset release; an unpowered card never drives
   always @(posedge i_sys_clk) begin
      if (!i_supply_en || !i_card_rst) cnt <= 0;
      else if (cnt < i_delay + 17) cnt <= cnt + 1;
      pull <= i_supply_en && cnt > i_delay && cnt <= i_delay + 16;
   end
   // open drain with pull-up: high once both sides let go
   assign o_card_io = !(i_dut_io_oe || pull);
endmodule

// ==== tb_top.sv ====
// testbench: activation, deactivation, data line, clock fault
`timescale 1ns/1ns
module tb_top;
   logic       clk, rstn, hclk, hrun, pdn, sel, hrst, sgood, fault, hpull;
   logic       sup_en, sel5, crst, cclk, dred, hoe, hpu, coe, cpu, cio, hdo, cdo;
   logic [7:0] seed;
   logic       exp_q[$];
   int         mismatches, checked, n, tot;
   wire        hdat = !(hoe || hpull);
   cas_sequencer dut_u (.i_sys_clk(clk), .i_resetn(rstn), .i_host_clk(hclk),
      .i_power_down_n(pdn), .i_supply_level_select(sel), .i_host_reset_in(hrst),
      .i_supply_good(sgood), .o_supply_en(sup_en), .o_supply_5v_sel(sel5),
      .o_card_rst(crst), .o_card_clk(cclk), .i_clk_fault(fault),
      .o_clk_drive_reduced(dred), .i_host_data(hdat), .o_host_data(hdo),
      .o_host_data_oe(hoe), .o_host_pullup_en(hpu), .i_card_io(cio), .o_card_io(cdo),
      .o_card_io_oe(coe), .o_card_pullup_en(cpu));
   cas_card_model card_u (.i_sys_clk(clk), .i_supply_en(sup_en), .i_card_rst(crst),
      .i_dut_io_oe(coe), .i_delay(seed), .o_card_io(cio));
   // system clock, 8 ns
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   // host clock, 6 ns, offset phase, can be stopped
   initial begin
      hclk = 0;
      #1;
      forever #3 if (hrun) hclk = ~hclk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic sig(input int i);
      logic [4:0] v;
      v = {hoe, crst, cclk, coe, sup_en};
      return v[i];
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // bounded wait for output i to reach v; running out ends the run
   task automatic wait_for(input int i, input logic v, input int lim, output int k);
      k = 0;
      while (sig(i) !== v && k < lim) begin
         tick(1);
         k++;
      end
      if (sig(i) !== v) begin
         mismatches++;
         give_verdict();
      end
   endtask
   initial begin
      {rstn, pdn, sel, hrst, sgood, fault, hpull} = 7'h00;
      hrun = 1;
      seed = 8'h09;
      mismatches = 0;
      checked = 0;
      tick(12);
      rstn = 1;
      tick(2);
      chk({sup_en, coe, crst, cclk}, 4'h4);
      for (int s = 0; s < 2; s++) begin
         seed = lfsr(seed);
         sel = s[0];
         exp_q.push_back(s[0]);
         tick(5);
         pdn = 1;
         wait_for(0, 1'b1, 10, n);
         chk({crst, cclk, coe, sel5}, {3'b001, exp_q.pop_front()});
         tick(20);
         chk(coe, 1'b1);
         sgood = 1;
         wait_for(1, 1'b0, 10, n);
         wait_for(2, 1'b1, 40, n);
         chk(n >= 2, 1'b1);
         chk({hoe, hdo, cdo}, 3'b000);
         chk(crst, 1'b0);
         hrst = 1;
         wait_for(3, 1'b1, 8, n);
         wait_for(4, 1'b1, 300, n);
         chk(hdat, 1'b0);
         wait_for(4, 1'b0, 40, n);
         tick(1);
         chk(hpu, 1'b1);
         hpull = 1;
         wait_for(1, 1'b1, 10, n);
         chk(cio, 1'b0);
         tick(seed[3:0]);
         hpull = 0;
         wait_for(1, 1'b0, 10, n);
         tick(1);
         chk(cpu, 1'b1);
         fault = 1;
         tick(cas_pkg::FAULT_DELAY_CYC - 8'h05);
         chk(dred, 1'b0);
         tick(10);
         chk(dred, 1'b1);
         fault = 0;
         tick(5);
         chk(dred, 1'b0);
         chk({hoe, coe}, 2'b00);
         // second pass stops the host clock high before the fall
         if (s == 1) begin
            @(posedge hclk);
            hrun = 0;
            tick(1);
         end
         pdn = 0;
         wait_for(3, 1'b0, 8, tot);
         chk(tot <= 5, 1'b1);
         tick(20);
         chk(cclk, s[0]);
         wait_for(1, 1'b1, 1200, n);
         tot = tot + 20 + n;
         chk(tot >= cas_pkg::DEACT_TIMEOUT_CYC && tot <= cas_pkg::DEACT_TIMEOUT_CYC + 9, 1'b1);
         chk({cclk, sup_en}, 2'b01);
         tick(1);
         chk(sup_en, 1'b0);
         {hrun, sgood, hrst} = 3'b100;
         tick(5);
         $display("test activation %0d done", s);
      end
      pdn = 1;
      wait_for(0, 1'b1, 10, n);
      pdn = 0;
      wait_for(0, 1'b0, 1200, n);
      chk(n >= 1100 && n <= 1140 && coe, 1'b1);
      $display("test abort done");
      give_verdict();
   end
endmodule
